/* rtl/scs_clock_switch.sv */
// scs_clock_switch: system clock source switch, start-up timers and reset sequencing
// assumes all inputs except rst_n synchronous to ref_clk; clock sources arrive as sampled levels
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module scs_clock_switch #(
	parameter int unsigned POWER_UP_DELAY_TIMER_CYC = scs_pkg::POWER_UP_DELAY_TIMER_CYC,    // power-up delay cycles
	parameter int unsigned LOCK_CYC = scs_pkg::LOCK_CYC     // multiplier lock wait cycles
) (
	input  wire logic        ref_clk,                       // block clock, 50 MHz
	input  wire logic        rst_n,                         // power-on reset, async
	input  wire logic [3:0]  avs_address,                   // byte address
	input  wire logic        avs_read,                      // read request
	input  wire logic        avs_write,                     // write request
	input  wire logic [31:0] avs_writedata,                 // write data
	output logic      [31:0] avs_readdata,                  // read data
	output logic             avs_waitrequest,               // low when answered
	input  wire logic [3:0]  osc_mode,                      // oscillator mode configuration
	input  wire logic        switching_feature_disable_n,   // zero enables switching
	input  wire logic        power_up_delay_timer_enable,                   // power-up delay enable
	input  wire logic        secondary_oscillator_enable,   // secondary oscillator on
	input  wire logic        oscillator_in_pin,             // primary source level
	input  wire logic        secondary_osc_in,              // secondary source level
	input  wire logic        external_reset_pin_n,          // external reset pin level
	input  wire logic        brown_out_reset,               // brown-out level
	input  wire logic        watchdog_timer_event,          // watchdog timeout pulse
	input  wire logic        reset_instr,                   // reset instruction pulse
	input  wire logic        stack_full_rst,                // stack full pulse
	input  wire logic        stack_underflow_rst,           // stack underflow pulse
	input  wire logic        wake_irq,                      // interrupt wake request
	input  wire logic        sleep_req,                     // sleep instruction
	input  wire logic        first_quarter_phase,           // core at first quarter
	output logic      [1:0]  sys_clk_sel,                   // active clock source
	output logic             cpu_stall,                     // core frozen
	output logic             cpu_reset,                     // core held in reset
	output logic             osc_enable,                    // primary oscillator running
	output logic             mult_enable,                   // multiplier powered
	output logic             oscillator_out_pin_o,          // second pin level
	output logic             oscillator_out_pin_oe          // second pin driven
);

	localparam int CW = scs_pkg::CNT_W;
	localparam int LW = scs_pkg::LK_W;
	localparam logic [CW-1:0] POWER_UP_DELAY_TIMER_LAST = CW'(POWER_UP_DELAY_TIMER_CYC - 1);
	localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// mode decoding

	function automatic logic is_crystal(input logic [3:0] m);
		return m == scs_pkg::MODE_LP || m == scs_pkg::MODE_XT || m == scs_pkg::MODE_HS
			|| m == scs_pkg::MODE_HS_FIXED || m == scs_pkg::MODE_HS_SOFT;
	endfunction : is_crystal

	function automatic logic fixed_mul(input logic [3:0] m);
		return m == scs_pkg::MODE_HS_FIXED || m == scs_pkg::MODE_EC_FIXED
			|| m == scs_pkg::MODE_EXTERNAL_CLOCK_IO_MODE_FIXD;
	endfunction : fixed_mul

	function automatic logic soft_mul(input logic [3:0] m);
		return m == scs_pkg::MODE_HS_SOFT || m == scs_pkg::MODE_EXTERNAL_CLOCK_IO_MODE_SOFT;
	endfunction : soft_mul

	function automatic logic low_in_sleep(input logic [3:0] m);
		return m == scs_pkg::MODE_RC || m == scs_pkg::MODE_EC;
	endfunction : low_in_sleep

	function automatic scs_pkg::scs_src_t want_src(input logic [3:0] m, input logic sec, input logic mul);
		if (sec)
			return scs_pkg::SRC_SEC;
		if (fixed_mul(m) || (soft_mul(m) && mul))
			return scs_pkg::SRC_MUL;
		return scs_pkg::SRC_PRI;
	endfunction : want_src

	function automatic scs_pkg::scs_state_t first_wait(input logic [3:0] m, input logic stopped,
		input scs_pkg::scs_src_t t);
		if (is_crystal(m) && stopped)
			return scs_pkg::ST_OST;
		if (t == scs_pkg::SRC_MUL)
			return scs_pkg::ST_LOCK;
		return scs_pkg::ST_SYNC;
	endfunction : first_wait

	////////////////////////////////////////////////////////////////////////////
	// state

	scs_pkg::scs_st_t q;
	scs_pkg::scs_st_t n;
	logic             wr;
	logic             osc_edge;
	logic             sec_edge;
	logic             tgt_edge;
	logic             go;
	logic             go_power_up_delay_timer;
	logic [3:0]       go_cause;
	scs_pkg::scs_src_t want;

	always_comb
	begin
		n        = q;
		wr       = avs_write && !q.waitreq;
		osc_edge = oscillator_in_pin && !q.osc_p;
		sec_edge = secondary_osc_in && !q.sec_p;
		tgt_edge = (q.tgt == scs_pkg::SRC_SEC) ? sec_edge : osc_edge;
		want     = want_src(osc_mode, q.sel_sec, q.sel_mul);
		n.osc_p  = oscillator_in_pin;
		n.sec_p  = secondary_osc_in;

		// pin filter: only a low held FILT_CYC cycles counts
		if (external_reset_pin_n)
			n.filt = 3'h0;
		else if (q.filt != scs_pkg::FILT_MAX)
			n.filt = q.filt + 3'h1;
		n.ext_low = (q.filt == scs_pkg::FILT_MAX);

		// multiplier lock timer
		// lock wait only starts once the start-up count is over
		if (!(q.pll_en && q.osc_run) || q.st == scs_pkg::ST_OST)
		begin
			n.lk_cnt = '0;
			n.lock   = 1'b0;
		end
		else if (q.lk_cnt == LOCK_LAST)
			n.lock = 1'b1;
		else
			n.lk_cnt = q.lk_cnt + 1'b1;

		// register port
		if (wr && avs_address == scs_pkg::OFS_OSC_CTRL)
		begin
			n.pll_en  = avs_writedata[scs_pkg::BIT_PLL_EN];
			n.sel_mul = avs_writedata[scs_pkg::BIT_SEL_MUL];
			n.sel_sec = avs_writedata[scs_pkg::BIT_SEL_SEC];
		end
		if (fixed_mul(osc_mode))
			n.pll_en = 1'b1;
		else if (!soft_mul(osc_mode))
			n.pll_en = 1'b0;
		if (!(n.pll_en && n.lock && soft_mul(osc_mode)))
			n.sel_mul = 1'b0;
		if (switching_feature_disable_n || !secondary_oscillator_enable)
			n.sel_sec = 1'b0;
		if ((avs_read || avs_write) && q.waitreq)
		begin
			n.waitreq = 1'b0;
			case (avs_address)
				scs_pkg::OFS_OSC_CTRL: n.rdata = {4'h0, q.lock, q.pll_en, q.sel_mul, q.sel_sec};
				scs_pkg::OFS_CAUSE:    n.rdata = {4'h0, q.cause};
				default:               n.rdata = 8'h00;
			endcase
		end
		else
			n.waitreq = 1'b1;

		// source sequencing
		case (q.st)
			scs_pkg::ST_POWER_UP_DELAY_TIMER:
			begin
				n.cnt = q.cnt + 1'b1;
				if (!power_up_delay_timer_enable || q.cnt == POWER_UP_DELAY_TIMER_LAST)
				begin
					n.cnt     = '0;
					n.osc_run = 1'b1;
					n.tgt     = want_src(osc_mode, 1'b0, 1'b0);
					n.st      = first_wait(osc_mode, !q.osc_run, n.tgt);
				end
			end
			scs_pkg::ST_OST:
			begin
				if (osc_edge)
				begin
					n.cnt = q.cnt + 1'b1;
					if (q.cnt == scs_pkg::OST_LAST)
					begin
						n.cnt = '0;
						n.st  = (q.tgt == scs_pkg::SRC_MUL) ? scs_pkg::ST_LOCK : scs_pkg::ST_SYNC;
					end
				end
			end
			scs_pkg::ST_LOCK:
			begin
				if (q.lock)
				begin
					n.cnt = '0;
					n.st  = scs_pkg::ST_SYNC;
				end
			end
			scs_pkg::ST_SYNC:
			begin
				if (tgt_edge)
				begin
					n.cnt = q.cnt + 1'b1;
					if (q.cnt == scs_pkg::SYNC_LAST)
					begin
						n.cnt     = '0;
						n.cur     = q.tgt;
						n.stall   = 1'b0;
						n.rst_out = 1'b0;
						n.osc_run = (q.tgt != scs_pkg::SRC_SEC);
						n.st      = scs_pkg::ST_RUN;
					end
				end
			end
			scs_pkg::ST_RUN:
			begin
				if (first_quarter_phase && sleep_req)
				begin
					n.st      = scs_pkg::ST_SLEEP;
					n.stall   = 1'b1;
					n.osc_run = 1'b0;
					n.out_oe  = low_in_sleep(osc_mode);
				end
				else if (first_quarter_phase && want != q.cur)
				begin
					n.stall   = 1'b1;
					n.tgt     = want;
					n.cnt     = '0;
					n.osc_run = q.osc_run || want != scs_pkg::SRC_SEC;
					n.st      = (want == scs_pkg::SRC_SEC) ? scs_pkg::ST_SYNC
						: first_wait(osc_mode, !q.osc_run, want);
				end
			end
			scs_pkg::ST_SLEEP:
			begin
				if (wake_irq || watchdog_timer_event)
				begin
					n.out_oe  = 1'b0;
					n.tgt     = q.cur;
					n.cnt     = '0;
					n.osc_run = (q.cur != scs_pkg::SRC_SEC);
					n.st      = (q.cur == scs_pkg::SRC_SEC) ? scs_pkg::ST_SYNC
						: first_wait(osc_mode, 1'b1, q.cur);
				end
			end
			default:
				n.st = scs_pkg::ST_RUN;
		endcase

		// reset kinds, highest priority first
		go       = 1'b1;
		go_power_up_delay_timer  = 1'b0;
		go_cause = q.cause;
		if (brown_out_reset)
		begin
			go_power_up_delay_timer  = 1'b1;
			go_cause = scs_pkg::CAUSE_BOR;
		end
		else if (q.ext_low && q.st != scs_pkg::ST_POWER_UP_DELAY_TIMER)
			go_cause = (q.st == scs_pkg::ST_SLEEP) ? scs_pkg::CAUSE_EXT_SLEEP
				: (q.rst_out ? q.cause : scs_pkg::CAUSE_EXT_RUN);
		else if (watchdog_timer_event && q.st != scs_pkg::ST_SLEEP)
			go_cause = scs_pkg::CAUSE_WDT;
		else if (reset_instr)
			go_cause = scs_pkg::CAUSE_INSTR;
		else if (stack_full_rst)
			go_cause = scs_pkg::CAUSE_STK_FULL;
		else if (stack_underflow_rst)
			go_cause = scs_pkg::CAUSE_STK_UNDER;
		else
			go = 1'b0;

		if (go)
		begin
			n.rst_out = 1'b1;
			n.stall   = 1'b1;
			n.cause   = go_cause;
			n.sel_sec = 1'b0;
			n.sel_mul = 1'b0;
			n.pll_en  = fixed_mul(osc_mode);
			n.tgt     = want_src(osc_mode, 1'b0, 1'b0);
			n.cnt     = '0;
			n.out_oe  = 1'b0;
			n.osc_run = !go_power_up_delay_timer;
			if (go_power_up_delay_timer && power_up_delay_timer_enable)
				n.st = scs_pkg::ST_POWER_UP_DELAY_TIMER;
			else
				n.st = first_wait(osc_mode, go_power_up_delay_timer || !q.osc_run, n.tgt);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= scs_pkg::RESET_STATE;
		else
			q <= n;
	end

	assign avs_readdata          = {24'h00_0000, q.rdata};
	assign avs_waitrequest       = q.waitreq;
	assign sys_clk_sel           = q.cur;
	assign cpu_stall             = q.stall;
	assign cpu_reset             = q.rst_out;
	assign osc_enable            = q.osc_run;
	assign mult_enable           = q.pll_en;
	assign oscillator_out_pin_o  = 1'b0;
	assign oscillator_out_pin_oe = q.out_oe;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	chk_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:4] == 28'h000_0000)
		else $error("upper control bits not zero");
	chk_lock_wait: assert property ($rose(q.lock) |-> $past(q.lk_cnt) == LOCK_LAST)
		else $error("lock set before lock wait");
	chk_mul_sel: assert property (q.sel_mul |-> q.pll_en && q.lock)
		else $error("multiplier select without enable and lock");
	chk_sec_sel: assert property (q.sel_sec |-> $past(!switching_feature_disable_n && secondary_oscillator_enable))
		else $error("secondary select not forced clear");
	chk_pll_mode: assert property ($past(rst_n) && !$past(soft_mul(osc_mode))
		|-> q.pll_en == $past(fixed_mul(osc_mode)))
		else $error("multiplier enable wrong for mode");
	chk_sec_prio: assert property (q.st == scs_pkg::ST_RUN && q.sel_sec && first_quarter_phase && !sleep_req && !go
		&& q.cur != scs_pkg::SRC_SEC |=> q.tgt == scs_pkg::SRC_SEC && q.stall)
		else $error("secondary select not taken first");
	chk_sync_count: assert property ($changed(q.cur) |-> $past(q.st == scs_pkg::ST_SYNC && q.cnt == scs_pkg::SYNC_LAST))
		else $error("source changed without eight edges");
	chk_ost_count: assert property ($past(q.st == scs_pkg::ST_OST) && q.st != scs_pkg::ST_OST && !$past(go)
		|-> $past(q.cnt) == scs_pkg::OST_LAST)
		else $error("start-up count not 1024 edges");
	chk_lock_gate: assert property ($past(q.st == scs_pkg::ST_LOCK) && q.st == scs_pkg::ST_SYNC |-> $past(q.lock))
		else $error("lock wait skipped");
	chk_power_up_delay_timer_len: assert property ($past(q.st == scs_pkg::ST_POWER_UP_DELAY_TIMER) && q.st != scs_pkg::ST_POWER_UP_DELAY_TIMER && !$past(go)
		&& $past(power_up_delay_timer_enable) |-> $past(q.cnt) == POWER_UP_DELAY_TIMER_LAST)
		else $error("power-up delay wrong length");
	chk_sleep_pins: assert property ($rose(q.st == scs_pkg::ST_SLEEP) |-> !q.osc_run && q.stall
		&& q.out_oe == low_in_sleep($past(osc_mode)))
		else $error("sleep entry wrong");
	chk_wake: assert property (q.st == scs_pkg::ST_SLEEP && (wake_irq || watchdog_timer_event) |=> q.st != scs_pkg::ST_SLEEP)
		else $error("sleep not left on wake");
	chk_reset_clear: assert property (go |=> !q.sel_sec && q.rst_out && q.stall && q.cause == $past(go_cause))
		else $error("reset did not clear selection");

	cov_to_sec: cover property ($rose(q.cur == scs_pkg::SRC_SEC));
	cov_from_sec: cover property ($fell(q.cur == scs_pkg::SRC_SEC) && q.st == scs_pkg::ST_RUN);
	cov_sleep_wake: cover property (q.st == scs_pkg::ST_SLEEP ##1 q.st != scs_pkg::ST_SLEEP && !q.rst_out);

endmodule : scs_clock_switch

`default_nettype wire

/* rtl/scs_pkg.sv */
// scs_pkg: constants, encodings and state record of the system clock switch
// assumes a 50 MHz ref_clk and byte addresses on an Avalon-MM register port
package scs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_MHZ      = 50;
	localparam int unsigned POWER_UP_DELAY_TIMER_TIME_US = 72000;
	localparam int unsigned LOCK_TIME_US = 2000;
	localparam int unsigned POWER_UP_DELAY_TIMER_CYC     = POWER_UP_DELAY_TIMER_TIME_US * CLK_MHZ;
	localparam int unsigned LOCK_CYC     = LOCK_TIME_US * CLK_MHZ;
	localparam int unsigned OST_EDGES    = 1024;
	localparam int unsigned SYNC_EDGES   = 8;
	localparam int unsigned FILT_CYC     = 4;
	localparam int unsigned CNT_W        = 22;
	localparam int unsigned LK_W         = 17;
	localparam logic [CNT_W-1:0] OST_LAST  = CNT_W'(OST_EDGES - 1);
	localparam logic [CNT_W-1:0] SYNC_LAST = CNT_W'(SYNC_EDGES - 1);
	localparam logic [2:0]       FILT_MAX  = 3'(FILT_CYC);

	////////////////////////////////////////////////////////////////////////////
	// register map and fields
	localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
	localparam logic [3:0] OFS_CAUSE    = 4'h4;
	localparam int unsigned BIT_LOCK    = 3;
	localparam int unsigned BIT_PLL_EN  = 2;
	localparam int unsigned BIT_SEL_MUL = 1;
	localparam int unsigned BIT_SEL_SEC = 0;

	////////////////////////////////////////////////////////////////////////////
	// encodings
	typedef enum logic [1:0] {
		SRC_PRI = 2'h0,
		SRC_MUL = 2'h1,
		SRC_SEC = 2'h2
	} scs_src_t;

	typedef enum logic [3:0] {
		MODE_LP        = 4'h0,
		MODE_XT        = 4'h1,
		MODE_HS        = 4'h2,
		MODE_RC        = 4'h3,
		MODE_EC        = 4'h4,
		MODE_EXTERNAL_CLOCK_IO_MODE      = 4'h5,
		MODE_RESISTOR_CAPACITOR_IO_MODE      = 4'h6,
		MODE_HS_FIXED  = 4'h7,
		MODE_EC_FIXED  = 4'h8,
		MODE_EXTERNAL_CLOCK_IO_MODE_FIXD = 4'h9,
		MODE_HS_SOFT   = 4'ha,
		MODE_EXTERNAL_CLOCK_IO_MODE_SOFT = 4'hb
	} scs_mode_t;

	typedef enum logic [3:0] {
		CAUSE_NONE      = 4'h0,
		CAUSE_POR       = 4'h1,
		CAUSE_EXT_RUN   = 4'h2,
		CAUSE_EXT_SLEEP = 4'h3,
		CAUSE_WDT       = 4'h4,
		CAUSE_BOR       = 4'h5,
		CAUSE_INSTR     = 4'h6,
		CAUSE_STK_FULL  = 4'h7,
		CAUSE_STK_UNDER = 4'h8
	} scs_cause_t;

	typedef enum logic [5:0] {
		ST_POWER_UP_DELAY_TIMER  = 6'h01,
		ST_OST   = 6'h02,
		ST_LOCK  = 6'h04,
		ST_SYNC  = 6'h08,
		ST_RUN   = 6'h10,
		ST_SLEEP = 6'h20
	} scs_state_t;

	typedef struct packed {
		scs_state_t       st;
		scs_src_t         cur;
		scs_src_t         tgt;
		logic [CNT_W-1:0] cnt;
		logic [LK_W-1:0]  lk_cnt;
		logic             lock;
		logic             pll_en;
		logic             sel_mul;
		logic             sel_sec;
		logic             stall;
		logic             rst_out;
		logic             osc_run;
		logic             out_oe;
		logic             ext_low;
		logic             osc_p;
		logic             sec_p;
		logic             waitreq;
		logic [3:0]       cause;
		logic [2:0]       filt;
		logic [7:0]       rdata;
	} scs_st_t;

	localparam scs_st_t RESET_STATE = '{
		st: ST_POWER_UP_DELAY_TIMER, cur: SRC_PRI, tgt: SRC_PRI, cnt: '0, lk_cnt: '0,
		lock: 1'b0, pll_en: 1'b0, sel_mul: 1'b0, sel_sec: 1'b0,
		stall: 1'b1, rst_out: 1'b1, osc_run: 1'b0, out_oe: 1'b0,
		ext_low: 1'b0, osc_p: 1'b0, sec_p: 1'b0, waitreq: 1'b1,
		cause: CAUSE_POR, filt: 3'h0, rdata: 8'h00
	};

endpackage : scs_pkg

/* verif/scs_osc_model.sv */
// scs_osc_model: far-side clock sources, delivered as levels sampled on ref_clk
// assumes ref_clk is the bench clock; a stopped source stands still at its last level
`timescale 1ns/1ps
`default_nettype none

module scs_osc_model #(
	parameter int unsigned PRI_HALF = 1,    // primary half period in ref_clk cycles
	parameter int unsigned SEC_HALF = 2     // secondary half period in ref_clk cycles
) (
	input  wire logic ref_clk,              // bench clock
	input  wire logic pri_run,              // primary oscillator powered
	input  wire logic sec_run,              // secondary oscillator powered
	output var  logic pri_out,              // primary source level
	output var  logic sec_out               // secondary source level
);
	int unsigned pri_cnt = 0;
	int unsigned sec_cnt = 0;
	logic        pri_lvl = 1'b0;
	logic        sec_lvl = 1'b0;

	assign pri_out = pri_lvl;
	assign sec_out = sec_lvl;

	////////////////////////////////////////////////////////////////////////////
	// each source toggles only while powered
	always @(posedge ref_clk)
	begin
		if (pri_run)
		begin
			pri_cnt = (pri_cnt + 1) % PRI_HALF;
			if (pri_cnt == 0)
				pri_lvl <= ~pri_lvl;
		end
		if (sec_run)
		begin
			sec_cnt = (sec_cnt + 1) % SEC_HALF;
			if (sec_cnt == 0)
				sec_lvl <= ~sec_lvl;
		end
	end
endmodule : scs_osc_model

`default_nettype wire

/* verif/system_clock_switch_and_reset_delay_test.sv */
// system_clock_switch_and_reset_delay_test: self-checking bench of the clock switch
// assumes shortened power-up and lock counts and the oscillator model on the far side
`timescale 1ns/1ps
`default_nettype none

module system_clock_switch_and_reset_delay_test;
	localparam int unsigned POWER_UP_DELAY_TIMER_C = 200;
	localparam int unsigned LOCK_C = 50;
	localparam int unsigned SEC_H  = 2;
	localparam logic [3:0]  CTRL   = scs_pkg::OFS_OSC_CTRL;
	localparam logic [3:0]  CAUSE  = scs_pkg::OFS_CAUSE;

	logic        ref_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [3:0]  osc_mode = scs_pkg::MODE_HS_SOFT;
	logic        power_up_delay_timer_en = 1'b1;
	logic        sec_en = 1'b0;
	logic        ext_n = 1'b1;
	logic        wdt = 1'b0;
	logic        wake = 1'b0;
	logic        instr = 1'b0;
	logic        bo = 1'b0;
	logic        sleep = 1'b0;
	logic        fq = 1'b0;
	logic [1:0]  fq_cnt = 2'h0;
	logic        pri, sec;
	logic [1:0]  sys_clk_sel;
	logic        cpu_stall, cpu_reset, osc_enable, mult_enable, pin_o, pin_oe;
	logic [31:0] rd;
	int          n, stl;
	int          fails = 0;
	int          checks = 0;

	always #10 ref_clk = ~ref_clk;

	// core first quarter marker, one cycle in four
	always @(posedge ref_clk)
	begin
		fq_cnt <= fq_cnt + 2'h1;
		fq <= (fq_cnt == 2'h3);
	end

	scs_clock_switch #(.POWER_UP_DELAY_TIMER_CYC(POWER_UP_DELAY_TIMER_C), .LOCK_CYC(LOCK_C)) scs_clock_switch_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .osc_mode(osc_mode), .switching_feature_disable_n(1'b0),
		.power_up_delay_timer_enable(power_up_delay_timer_en), .secondary_oscillator_enable(sec_en), .oscillator_in_pin(pri),
		.secondary_osc_in(sec), .external_reset_pin_n(ext_n), .brown_out_reset(bo),
		.watchdog_timer_event(wdt), .reset_instr(instr), .stack_full_rst(1'b0),
		.stack_underflow_rst(1'b0), .wake_irq(wake), .sleep_req(sleep), .first_quarter_phase(fq),
		.sys_clk_sel(sys_clk_sel), .cpu_stall(cpu_stall), .cpu_reset(cpu_reset),
		.osc_enable(osc_enable), .mult_enable(mult_enable), .oscillator_out_pin_o(pin_o),
		.oscillator_out_pin_oe(pin_oe));

	scs_osc_model #(.PRI_HALF(1), .SEC_HALF(SEC_H)) scs_osc_model_i (
		.ref_clk(ref_clk), .pri_run(osc_enable), .sec_run(sec_en), .pri_out(pri), .sec_out(sec));

	////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task automatic hang(input string what);
		fails++;
		$display("wrong value %s expected done seen timeout", what);
		complete_run();
	endtask : hang

	// one request held until waitrequest is low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int k;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_read <= ~wr;
		avs_write <= wr;
		k = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50)
			hang("bus answer");
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
		bus(1'b0, a, 8'h00);
		check(what, rd, {24'h00_0000, exp});
	endtask : rd_chk

	task automatic wait_run();
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (cpu_reset !== 1'b0 && n < 20000);
		if (n >= 20000)
			hang("reset release");
	endtask : wait_run

	task automatic wait_sel(input logic [1:0] exp, input int lim);
		n = 0;
		stl = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
			if (cpu_stall === 1'b1)
				stl++;
		end
		while (!(sys_clk_sel === exp && cpu_stall === 1'b0) && n < lim);
		if (n >= lim)
			hang("source handover");
	endtask : wait_sel

	task automatic do_reset(input logic [3:0] mode, input logic power_up_delay_timer);
		rst_n <= 1'b0;
		osc_mode <= mode;
		power_up_delay_timer_en <= power_up_delay_timer;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		wait_run();
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_power_on();
		do_reset(scs_pkg::MODE_HS_SOFT, 1'b1);
		check("startup cycles", 32'(n >= POWER_UP_DELAY_TIMER_C + 2 * 1024), 32'h1);
		check("selected source", {30'h0, sys_clk_sel}, 32'h0);
		rd_chk(CTRL, 8'h00, "control after reset");
		rd_chk(CAUSE, 8'h01, "cause power-on");
		rd_chk(4'h8, 8'h00, "unmapped read");
		$display("test power_on done");
	endtask : t_power_on

	task automatic t_ctrl_bits();
		bus(1'b1, CTRL, 8'hf5);
		rd_chk(CTRL, 8'h04, "upper bits and secondary refused");
		check("multiplier powered", {31'h0, mult_enable}, 32'h1);
		repeat (LOCK_C + 8) @(posedge ref_clk);
		rd_chk(CTRL, 8'h0c, "lock status");
		sec_en <= 1'b1;
		bus(1'b1, CTRL, 8'h06);
		rd_chk(CTRL, 8'h0e, "multiplier select");
		wait_sel(2'h1, 400);
		check("stall on handover", 32'(stl > 0), 32'h1);
		$display("test ctrl_bits done");
	endtask : t_ctrl_bits

	task automatic t_secondary();
		bus(1'b1, CTRL, 8'h07);
		wait_sel(2'h2, 400);
		check("secondary wins", {30'h0, sys_clk_sel}, 32'h2);
		check("secondary sync stall", 32'(stl >= 7 * 2 * SEC_H), 32'h1);
		rd_chk(CTRL, 8'h05, "lock lost on secondary");
		bus(1'b1, CTRL, 8'h04);
		wait_sel(2'h0, 6000);
		check("crystal return wait", 32'(stl >= 2 * 1024), 32'h1);
		$display("test secondary done");
	endtask : t_secondary

	task automatic t_fixed();
		do_reset(scs_pkg::MODE_HS_FIXED, 1'b0);
		check("fixed startup cycles", 32'(n >= 2 * 1024 + LOCK_C), 32'h1);
		bus(1'b1, CTRL, 8'h00);
		rd_chk(CTRL, 8'h0c, "enable forced set");
		$display("test fixed done");
	endtask : t_fixed

	task automatic t_sleep();
		do_reset(scs_pkg::MODE_RC, 1'b0);
		check("rc startup short", 32'(n < 40), 32'h1);
		bus(1'b1, CTRL, 8'h04);
		rd_chk(CTRL, 8'h00, "enable forced clear");
		@(posedge ref_clk);
		sleep <= 1'b1;
		repeat (8) @(posedge ref_clk);
		sleep <= 1'b0;
		@(negedge ref_clk);
		check("sleep pins", {28'h0, cpu_stall, osc_enable, pin_oe, pin_o}, 32'ha);
		@(posedge ref_clk);
		wake <= 1'b1;
		@(posedge ref_clk);
		wake <= 1'b0;
		wait_sel(2'h0, 100);
		check("awake pins", {30'h0, osc_enable, pin_oe}, 32'h2);
		rd_chk(CAUSE, 8'h01, "cause kept on wake");
		@(posedge ref_clk);
		ext_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		ext_n <= 1'b1;
		repeat (4) @(negedge ref_clk);
		check("short pulse ignored", {31'h0, cpu_reset}, 32'h0);
		@(posedge ref_clk);
		ext_n <= 1'b0;
		repeat (10) @(negedge ref_clk);
		check("pin reset held", {31'h0, cpu_reset}, 32'h1);
		@(posedge ref_clk);
		ext_n <= 1'b1;
		wait_run();
		rd_chk(CAUSE, 8'h02, "cause pin reset");
		@(posedge ref_clk);
		wdt <= 1'b1;
		@(posedge ref_clk);
		wdt <= 1'b0;
		repeat (3) @(negedge ref_clk);
		check("watchdog reset", {31'h0, cpu_reset}, 32'h1);
		wait_run();
		rd_chk(CAUSE, 8'h04, "cause watchdog");
		$display("test sleep done");
	endtask : t_sleep

	task automatic t_resets();
		@(posedge ref_clk);
		instr <= 1'b1;
		@(posedge ref_clk);
		instr <= 1'b0;
		wait_run();
		rd_chk(CAUSE, 8'h06, "cause instruction");
		@(posedge ref_clk);
		power_up_delay_timer_en <= 1'b1;
		bo <= 1'b1;
		repeat (2) @(posedge ref_clk);
		bo <= 1'b0;
		wait_run();
		check("brown-out delay", 32'(n >= POWER_UP_DELAY_TIMER_C), 32'h1);
		rd_chk(CAUSE, 8'h05, "cause brown-out");
		rd_chk(CTRL, 8'h00, "control after brown-out");
		$display("test resets done");
	endtask : t_resets

	initial
	begin
		t_power_on();
		t_ctrl_bits();
		t_secondary();
		t_fixed();
		t_sleep();
		t_resets();
		complete_run();
	end
endmodule : system_clock_switch_and_reset_delay_test

`default_nettype wire
